//--- rtl/icpa_pkg.sv
// Purpose: Shared constants for the indexed configuration port block.
// Assumes: Byte-wide configuration registers behind a 16-bit I/O bus.
// Notes: Legacy ranges are listed as parallel tables indexed by select bit.
package icpa_pkg;
    localparam int ICPA_ADDR_W = 16;
    localparam int ICPA_DATA_W = 16;
    localparam int ICPA_BYTE_W = 8;
    localparam int ICPA_IDX_W = 8;
    localparam int ICPA_NUM_GROUPS = 4;
    localparam int ICPA_NUM_LANES = 2;

    // Group numbers, used as generate and array indices.
    localparam int ICPA_GRP_SETUP = 0;
    localparam int ICPA_GRP_CLOCK = 1;
    localparam int ICPA_GRP_DISPLAY = 2;
    localparam int ICPA_GRP_CARD = 3;

    // Index and data port addresses.
    localparam logic [15:0] ICPA_SETUP_CONTROL_INDEX = 16'h0022;
    localparam logic [15:0] ICPA_SETUP_CONTROL_DATA = 16'h0023;
    localparam logic [15:0] ICPA_CLOCK_RAM_INDEX = 16'h0070;
    localparam logic [15:0] ICPA_CLOCK_RAM_DATA = 16'h0071;
    localparam logic [15:0] ICPA_MONO_DISPLAY_INDEX = 16'h03B4;
    localparam logic [15:0] ICPA_MONO_DISPLAY_DATA = 16'h03B5;
    localparam logic [15:0] ICPA_COLOUR_DISPLAY_INDEX = 16'h03D4;
    localparam logic [15:0] ICPA_COLOUR_DISPLAY_DATA = 16'h03D5;
    localparam logic [15:0] ICPA_CARD_SOCKET_INDEX = 16'h03E0;
    localparam logic [15:0] ICPA_CARD_SOCKET_DATA = 16'h03E1;

    // Reset and idle values.
    localparam logic [7:0] ICPA_INDEX_RESET = 8'h00;
    localparam logic [7:0] ICPA_REG_RESET = 8'h00;
    localparam logic [7:0] ICPA_UNMAPPED_READ = 8'hFF;

    // Directly decoded legacy port ranges, one select bit each.
    localparam int ICPA_LEG_N = 22;
    localparam logic [15:0] ICPA_LEG_LO [ICPA_LEG_N] = '{
        16'h0000, 16'h0020, 16'h0040, 16'h0060, 16'h0061, 16'h0064, 16'h0080, 16'h0081,
        16'h0084, 16'h0087, 16'h0088, 16'h0089, 16'h008C, 16'h0092, 16'h00A0, 16'h00C0,
        16'h00EE, 16'h00EF, 16'h0278, 16'h02F8, 16'h0378, 16'h03F8};
    localparam logic [15:0] ICPA_LEG_HI [ICPA_LEG_N] = '{
        16'h000F, 16'h0021, 16'h0043, 16'h0060, 16'h0061, 16'h0064, 16'h0080, 16'h0083,
        16'h0086, 16'h0087, 16'h0088, 16'h008B, 16'h008F, 16'h0092, 16'h00A1, 16'h00DE,
        16'h00EE, 16'h00EF, 16'h027F, 16'h02FF, 16'h037F, 16'h03FF};
    // Ranges that decode even addresses only.
    localparam logic [ICPA_LEG_N-1:0] ICPA_LEG_EVEN = 22'h008000;
endpackage : icpa_pkg

//--- rtl/icpa_group.sv
// Purpose: One indexed register group: an index latch and its register space.
// Assumes: Index and data writes may arrive in the same cycle.
// Notes: Read outputs are combinational; the top module registers them.
module icpa_group
    import icpa_pkg::*;
#(
    parameter int IDX_W = ICPA_IDX_W
) (
    input wire logic sys_clk_i, // System clock.
    input wire logic rst_i, // Asynchronous reset, active high.
    input wire logic idx_we_i, // Index latch write.
    input wire logic [7:0] idx_d_i, // Index value to latch.
    input wire logic dat_we_i, // Selected register write.
    input wire logic [7:0] dat_d_i, // Register write data.
    output logic [7:0] idx_o, // Current index latch value.
    output logic [7:0] dat_o // Register selected by the index latch.
);
    localparam int DEPTH = 2 ** IDX_W;

    typedef struct packed {
        logic [7:0] idx;
        logic [DEPTH-1:0][7:0] mem;
    } icpa_grp_s;

    icpa_grp_s st;
    icpa_grp_s next_st;
    logic [7:0] sel;

    always_comb begin
        next_st = st;
        sel = st.idx;
        if (idx_we_i) begin
            next_st.idx = idx_d_i;
            // A combined write selects by the index written in the same access.
            sel = idx_d_i;
        end
        if (dat_we_i) begin
            next_st.mem[sel[IDX_W-1:0]] = dat_d_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st.idx <= ICPA_INDEX_RESET;
            st.mem <= {DEPTH{ICPA_REG_RESET}};
        end else begin
            st <= next_st;
        end
    end

    assign idx_o = st.idx;
    assign dat_o = st.mem[st.idx[IDX_W-1:0]];
endmodule : icpa_group

//--- rtl/icpa_top.sv
// Purpose: I/O port front end giving access to four indexed register spaces and legacy ports.
// Assumes: Requests come from logic on sys_clk_i; colour_mode_i is a same-clock level.
// Notes: Lane 0 of an access is at io_addr_i, lane 1 at io_addr_i plus one.
module icpa_top
    import icpa_pkg::*;
#(
    parameter int IDX_W = ICPA_IDX_W
) (
    input wire logic sys_clk_i, // System clock, 25 MHz.
    input wire logic rst_i, // Asynchronous reset, active high.
    input wire logic [15:0] io_addr_i, // I/O port address of lane 0.
    input wire logic io_wr_i, // I/O write request, one-cycle pulse.
    input wire logic io_rd_i, // I/O read request, one-cycle pulse.
    input wire logic [1:0] io_be_i, // Byte lane enables.
    input wire logic [15:0] io_wdata_i, // Write data, lane 1 in the high byte.
    input wire logic colour_mode_i, // High selects colour text mode ports.
    input wire logic [15:0] legacy_rdata_i, // Read data from legacy peripherals.
    output logic io_ack_o, // Access completed, one-cycle pulse.
    output logic [15:0] io_rdata_o, // Read data, valid with io_ack_o.
    output logic io_busy_o, // Legacy access in flight, requests ignored.
    output logic [ICPA_LEG_N-1:0] legacy_sel_o, // One-hot legacy range select.
    output logic legacy_wr_o, // Legacy write strobe.
    output logic legacy_rd_o, // Legacy read strobe.
    output logic [15:0] legacy_addr_o, // Legacy access address.
    output logic [1:0] legacy_be_o, // Legacy byte enables.
    output logic [15:0] legacy_wdata_o // Legacy write data.
);
    typedef struct packed {
        logic ack;
        logic [15:0] rdata;
        logic pend;
        logic [ICPA_LEG_N-1:0] leg_sel;
        logic leg_wr;
        logic leg_rd;
        logic [15:0] leg_addr;
        logic [1:0] leg_be;
        logic [15:0] leg_wdata;
    } icpa_top_s;

    // Decoded indexed port: hit, data (not index), group number.
    typedef struct packed {
        logic hit;
        logic is_data;
        logic [1:0] grp;
    } icpa_port_s;

    icpa_top_s st;
    icpa_top_s next_st;

    logic [ICPA_NUM_GROUPS-1:0] grp_idx_we;
    logic [ICPA_NUM_GROUPS-1:0] grp_dat_we;
    logic [7:0] grp_idx_d [ICPA_NUM_GROUPS];
    logic [7:0] grp_dat_d [ICPA_NUM_GROUPS];
    logic [7:0] grp_idx_q [ICPA_NUM_GROUPS];
    logic [7:0] grp_dat_q [ICPA_NUM_GROUPS];

    function automatic icpa_port_s icpa_decode_port(input logic [15:0] a, input logic colour);
        icpa_port_s p;
        p = '0;
        p.hit = 1'b1;
        // Decoding is by address and colour mode only; no key or lock state exists.
        if (a == ICPA_SETUP_CONTROL_INDEX) begin
            p.grp = 2'(ICPA_GRP_SETUP);
        end else if (a == ICPA_SETUP_CONTROL_DATA) begin
            p.grp = 2'(ICPA_GRP_SETUP);
            p.is_data = 1'b1;
        end else if (a == ICPA_CLOCK_RAM_INDEX) begin
            p.grp = 2'(ICPA_GRP_CLOCK);
        end else if (a == ICPA_CLOCK_RAM_DATA) begin
            p.grp = 2'(ICPA_GRP_CLOCK);
            p.is_data = 1'b1;
        end else if (colour && a == ICPA_COLOUR_DISPLAY_INDEX) begin
            p.grp = 2'(ICPA_GRP_DISPLAY);
        end else if (colour && a == ICPA_COLOUR_DISPLAY_DATA) begin
            p.grp = 2'(ICPA_GRP_DISPLAY);
            p.is_data = 1'b1;
        end else if (!colour && a == ICPA_MONO_DISPLAY_INDEX) begin
            p.grp = 2'(ICPA_GRP_DISPLAY);
        end else if (!colour && a == ICPA_MONO_DISPLAY_DATA) begin
            p.grp = 2'(ICPA_GRP_DISPLAY);
            p.is_data = 1'b1;
        end else if (a == ICPA_CARD_SOCKET_INDEX) begin
            p.grp = 2'(ICPA_GRP_CARD);
        end else if (a == ICPA_CARD_SOCKET_DATA) begin
            p.grp = 2'(ICPA_GRP_CARD);
            p.is_data = 1'b1;
        end else begin
            p.hit = 1'b0;
        end
        return p;
    endfunction : icpa_decode_port

    function automatic logic [ICPA_LEG_N-1:0] icpa_decode_legacy(input logic [15:0] a);
        logic [ICPA_LEG_N-1:0] s;
        s = '0;
        for (int i = 0; i < ICPA_LEG_N; i++) begin
            if (a >= ICPA_LEG_LO[i] && a <= ICPA_LEG_HI[i] && !(ICPA_LEG_EVEN[i] && a[0])) begin
                s[i] = 1'b1;
            end
        end
        return s;
    endfunction : icpa_decode_legacy

    always_comb begin
        logic [15:0] lane_addr [ICPA_NUM_LANES];
        logic [ICPA_LEG_N-1:0] leg_hit;
        icpa_port_s p;
        lane_addr[0] = io_addr_i;
        lane_addr[1] = 16'(io_addr_i + 16'h0001);
        leg_hit = icpa_decode_legacy(io_addr_i);
        p = '0;
        next_st = st;
        next_st.ack = 1'b0;
        next_st.leg_sel = '0;
        next_st.leg_wr = 1'b0;
        next_st.leg_rd = 1'b0;
        grp_idx_we = '0;
        grp_dat_we = '0;
        for (int g = 0; g < ICPA_NUM_GROUPS; g++) begin
            grp_idx_d[g] = ICPA_INDEX_RESET;
            grp_dat_d[g] = ICPA_REG_RESET;
        end
        if (st.pend) begin
            // The peripheral drives its data while the strobe stands.
            next_st.pend = 1'b0;
            next_st.ack = 1'b1;
            next_st.rdata = st.leg_rd ? legacy_rdata_i : {ICPA_UNMAPPED_READ, ICPA_UNMAPPED_READ};
        end else if (io_wr_i || io_rd_i) begin
            if (leg_hit != '0) begin
                next_st.pend = 1'b1;
                next_st.leg_sel = leg_hit;
                next_st.leg_wr = io_wr_i;
                next_st.leg_rd = !io_wr_i;
                next_st.leg_addr = io_addr_i;
                next_st.leg_be = io_be_i;
                next_st.leg_wdata = io_wdata_i;
            end else begin
                next_st.ack = 1'b1;
                next_st.rdata = {ICPA_UNMAPPED_READ, ICPA_UNMAPPED_READ};
                for (int l = 0; l < ICPA_NUM_LANES; l++) begin
                    p = icpa_decode_port(lane_addr[l], colour_mode_i);
                    if (io_be_i[l] && p.hit) begin
                        // Only the addressed group is touched; others keep their index.
                        if (io_wr_i && !p.is_data) begin
                            grp_idx_we[p.grp] = 1'b1;
                            grp_idx_d[p.grp] = io_wdata_i[l*8 +: 8];
                        end else if (io_wr_i) begin
                            grp_dat_we[p.grp] = 1'b1;
                            grp_dat_d[p.grp] = io_wdata_i[l*8 +: 8];
                        end else if (p.is_data) begin
                            next_st.rdata[l*8 +: 8] = grp_dat_q[p.grp];
                        end else begin
                            next_st.rdata[l*8 +: 8] = grp_idx_q[p.grp];
                        end
                    end
                end
                if (io_wr_i) begin
                    next_st.rdata = {ICPA_UNMAPPED_READ, ICPA_UNMAPPED_READ};
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
            st.rdata <= {ICPA_UNMAPPED_READ, ICPA_UNMAPPED_READ};
        end else begin
            st <= next_st;
        end
    end

    for (genvar g = 0; g < ICPA_NUM_GROUPS; g++) begin : g_group
        icpa_group #(
            .IDX_W(IDX_W)
        ) u_group (
            .sys_clk_i(sys_clk_i),
            .rst_i(rst_i),
            .idx_we_i(grp_idx_we[g]),
            .idx_d_i(grp_idx_d[g]),
            .dat_we_i(grp_dat_we[g]),
            .dat_d_i(grp_dat_d[g]),
            .idx_o(grp_idx_q[g]),
            .dat_o(grp_dat_q[g])
        );
    end

    assign io_ack_o = st.ack;
    assign io_rdata_o = st.rdata;
    assign io_busy_o = st.pend;
    assign legacy_sel_o = st.leg_sel;
    assign legacy_wr_o = st.leg_wr;
    assign legacy_rd_o = st.leg_rd;
    assign legacy_addr_o = st.leg_addr;
    assign legacy_be_o = st.leg_be;
    assign legacy_wdata_o = st.leg_wdata;
endmodule : icpa_top

//--- sim/icpa_checker.sv
// Purpose: Port assertions for the indexed configuration port block.
// Assumes: One clock domain; bound to icpa_top.
// Notes: Index latches are shadowed here to judge read-back.
module icpa_checker
    import icpa_pkg::*;
(
    input wire logic sys_clk_i, // Clock.
    input wire logic rst_i, // Reset.
    input wire logic [15:0] io_addr_i, // Address.
    input wire logic io_wr_i, // Write.
    input wire logic io_rd_i, // Read.
    input wire logic [1:0] io_be_i, // Lanes.
    input wire logic [15:0] io_wdata_i, // Data.
    input wire logic colour_mode_i, // Mode.
    input wire logic [15:0] legacy_rdata_i, // Legacy data.
    input wire logic io_ack_o, // Ack.
    input wire logic [15:0] io_rdata_o, // Read data.
    input wire logic io_busy_o, // Busy.
    input wire logic [ICPA_LEG_N-1:0] legacy_sel_o, // Select.
    input wire logic legacy_wr_o, // Legacy write.
    input wire logic legacy_rd_o, // Legacy read.
    input wire logic [15:0] legacy_addr_o // Legacy address.
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    logic take, ix, rd_q;
    logic [2:0] gi;
    logic [15:0] a;
    logic [7:0] exp_q;
    logic [7:0] sh [4];
    assign take = (io_wr_i || io_rd_i) && !io_busy_o;
    assign ix = (gi != 3'h4);
    always_comb begin
        a = {io_addr_i[15:1], 1'b0};
        gi = 3'h4;
        if (a == ICPA_SETUP_CONTROL_INDEX) gi = 3'h0;
        if (a == ICPA_CLOCK_RAM_INDEX) gi = 3'h1;
        if (a == (colour_mode_i ? ICPA_COLOUR_DISPLAY_INDEX : ICPA_MONO_DISPLAY_INDEX)) gi = 3'h2;
        if (a == ICPA_CARD_SOCKET_INDEX) gi = 3'h3;
    end
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sh <= '{default: 8'h00};
            rd_q <= 1'b0;
            exp_q <= 8'h00;
        end else begin
            rd_q <= take && !io_wr_i && ix && !io_addr_i[0] && io_be_i[0];
            exp_q <= sh[gi[1:0]];
            if (take && io_wr_i && ix && !io_addr_i[0] && io_be_i[0]) sh[gi[1:0]] <= io_wdata_i[7:0];
        end
    end
    chk_idx_ack: assert property (take && ix |=> io_ack_o && !io_busy_o && !legacy_rd_o)
        else $error("indexed access not acked in one cycle");
    chk_idx_readback: assert property (rd_q |-> io_rdata_o[7:0] == exp_q)
        else $error("index read-back wrong");
    chk_wr_rdata: assert property (take && io_wr_i && ix |=> io_rdata_o == 16'hFFFF)
        else $error("write ack data wrong");
    chk_leg_strobe: assert property (legacy_rd_o || legacy_wr_o |-> io_busy_o && $onehot(legacy_sel_o)
        && legacy_addr_o == $past(io_addr_i))
        else $error("legacy strobe wrong");
    chk_leg_ack: assert property ($rose(io_busy_o) |=> io_ack_o && !io_busy_o)
        else $error("legacy ack late");
    chk_busy_refuse: assert property (io_busy_o |=> !legacy_rd_o && !legacy_wr_o)
        else $error("request taken while busy");
    chk_leg_rdata: assert property (legacy_rd_o |=> io_rdata_o == $past(legacy_rdata_i))
        else $error("legacy read data wrong");
    chk_ack_cause: assert property (io_ack_o |-> $past(take) || $past(io_busy_o))
        else $error("ack without request");
    cover property (rd_q);
    cover property ($rose(io_busy_o));
    cover property (take && io_wr_i && io_be_i == 2'h3 && ix);
endmodule : icpa_checker

//--- sim/icpa_legacy_model.sv
// Purpose: Legacy peripheral stand-in answering forwarded reads.
// Assumes: Data is taken at the edge that ends the strobe cycle.
// Notes: Outside a read the bus churns so stale data is never mistaken.
module icpa_legacy_model
    import icpa_pkg::*;
(
    input wire logic sys_clk_i, // Clock.
    input wire logic rst_i, // Reset.
    input wire logic legacy_rd_i, // Read strobe.
    input wire logic [15:0] legacy_addr_i, // Address.
    output logic [15:0] legacy_rdata_o // Read data.
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] junk;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) junk <= 16'h0000;
        else junk <= junk + 16'h9E37;
    end
    assign legacy_rdata_o = legacy_rd_i ? {legacy_addr_i[7:0], ~legacy_addr_i[7:0]} : junk;
endmodule : icpa_legacy_model

//--- sim/tb.sv
// Purpose: Random and corner tests of the indexed configuration port block.
// Assumes: Requests are spaced so none lands while busy.
// Notes: A reference copy of every group lives in the bench.
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module tb import icpa_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, io_wr_i = 1'b0, io_rd_i = 1'b0, colour_mode_i = 1'b0;
    logic [15:0] io_addr_i = 16'h0000, io_wdata_i = 16'h0000, legacy_rdata_i, io_rdata_o;
    logic [15:0] legacy_addr_o, legacy_wdata_o, rd_seen;
    logic [1:0] io_be_i = 2'h0, legacy_be_o;
    logic io_ack_o, io_busy_o, legacy_wr_o, legacy_rd_o, wr_seen;
    logic [ICPA_LEG_N-1:0] legacy_sel_o, sel_seen;
    logic [7:0] m_idx [4];
    logic [7:0] m_mem [4][256];
    int errors = 0, n_tests = 0, cyc = 0;
    icpa_top icpa_top_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
        .io_rd_i(io_rd_i), .io_be_i(io_be_i), .io_wdata_i(io_wdata_i), .colour_mode_i(colour_mode_i),
        .legacy_rdata_i(legacy_rdata_i), .io_ack_o(io_ack_o), .io_rdata_o(io_rdata_o), .io_busy_o(io_busy_o),
        .legacy_sel_o(legacy_sel_o), .legacy_wr_o(legacy_wr_o), .legacy_rd_o(legacy_rd_o),
        .legacy_addr_o(legacy_addr_o), .legacy_be_o(legacy_be_o), .legacy_wdata_o(legacy_wdata_o));
    icpa_legacy_model icpa_legacy_model_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .legacy_rd_i(legacy_rd_o),
        .legacy_addr_i(legacy_addr_o), .legacy_rdata_o(legacy_rdata_i));
    initial begin
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            end_sim();
        end
    end
    function automatic logic [15:0] port(input int g);
        case (g)
            0: return ICPA_SETUP_CONTROL_INDEX;
            1: return ICPA_CLOCK_RAM_INDEX;
            2: return colour_mode_i ? ICPA_COLOUR_DISPLAY_INDEX : ICPA_MONO_DISPLAY_INDEX;
            default: return ICPA_CARD_SOCKET_INDEX;
        endcase
    endfunction : port
    // The legacy stand-in answers with the low address byte and its inverse.
    function automatic logic [15:0] leg_exp(input logic [15:0] a);
        return {a[7:0], ~a[7:0]};
    endfunction : leg_exp
    // Request held through its taking edge, then released; ack awaited under a bound.
    task automatic io(input logic wr, input logic [15:0] a, input logic [1:0] be, input logic [15:0] wd);
        int w;
        @(negedge sys_clk_i);
        io_wr_i = wr;
        io_rd_i = !wr;
        io_addr_i = a;
        io_be_i = be;
        io_wdata_i = wd;
        @(negedge sys_clk_i);
        io_wr_i = 1'b0;
        io_rd_i = 1'b0;
        sel_seen = legacy_sel_o;
        wr_seen = legacy_wr_o;
        w = 0;
        while (io_ack_o !== 1'b1 && w < 4) begin
            @(negedge sys_clk_i);
            w++;
        end
        `CHK("ack", 1'b1, io_ack_o)
        rd_seen = io_rdata_o;
    endtask : io
    initial begin
        int g;
        int k;
        logic [15:0] v;
        m_idx = '{default: 8'h00};
        m_mem = '{default: '{default: 8'h00}};
        void'($urandom(32'h0F23));
        repeat (8) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        rst_i = 1'b0;
        `CHK("rdata_rst", 16'hFFFF, io_rdata_o)
        for (int i = 0; i < 400; i++) begin
            g = $urandom_range(3);
            colour_mode_i = 1'($urandom_range(1));
            v = 16'($urandom);
            v[7:0] = v[8] ? 8'hFF : {5'h00, v[2:0]};
            case ($urandom_range(5))
                0: begin
                    io(1'b1, port(g), 2'h1, v);
                    m_idx[g] = v[7:0];
                end
                1: begin
                    io(1'b1, port(g) + 16'h0001, 2'h1, v);
                    m_mem[g][m_idx[g]] = v[7:0];
                end
                2: begin
                    io(1'b1, port(g), 2'h3, v);
                    m_idx[g] = v[7:0];
                    m_mem[g][v[7:0]] = v[15:8];
                end
                3: begin
                    io(1'b0, port(g) + 16'h0001, 2'h1, v);
                    `CHK("data", {8'hFF, m_mem[g][m_idx[g]]}, rd_seen)
                end
                4: begin
                    io(1'b0, port(g), {v[10], 1'b1}, v);
                    `CHK("index", {(v[10] ? m_mem[g][m_idx[g]] : 8'hFF), m_idx[g]}, rd_seen)
                end
                default: begin
                    k = $urandom_range(ICPA_LEG_N - 1);
                    io(v[9], ICPA_LEG_LO[k], 2'h3, v);
                    if (!v[9]) `CHK("legacy", leg_exp(ICPA_LEG_LO[k]), rd_seen)
                    `CHK("sel", ICPA_LEG_N'(1) << k, sel_seen)
                    `CHK("leg_bus", {v[9], 2'h3, v}, {wr_seen, legacy_be_o, legacy_wdata_o})
                end
            endcase
        end
        colour_mode_i = 1'b1;
        io(1'b0, ICPA_MONO_DISPLAY_DATA, 2'h1, 16'h0000);
        `CHK("inactive", 16'hFFFF, rd_seen)
        end_sim();
    end
endmodule : tb
bind icpa_top icpa_checker icpa_checker_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .io_addr_i(io_addr_i),
    .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_be_i(io_be_i), .io_wdata_i(io_wdata_i),
    .colour_mode_i(colour_mode_i), .legacy_rdata_i(legacy_rdata_i), .io_ack_o(io_ack_o),
    .io_rdata_o(io_rdata_o), .io_busy_o(io_busy_o), .legacy_sel_o(legacy_sel_o),
    .legacy_wr_o(legacy_wr_o), .legacy_rd_o(legacy_rd_o), .legacy_addr_o(legacy_addr_o));
